// [hdl/alarm_autoreset.sv]
// Alarm autoreset controller with a classic Wishbone register slave
`default_nettype none
// What this block does
// - Autoreset active only when the attempt limit, 0 to 10, is above zero.
// - No autoreset while any alarm condition is still abnormal.
// - Attempt count above the limit aborts autoreset entirely.
// - Count drops by one per trip-free ten minutes, never below zero.
// - When the count exceeds a non-zero limit, tag the trip record stamp with letter A.
// - A normal reset command clears the attempt count to zero.
// - Attempt count is a read-only status value, zero after reset.
// - While pending, flash trip and run indicators together and raise flag.
// - Autoreset only while the external enable signal is active.
// - Level start with a run input active starts the motor on reset.
// - Autoreset waits until remaining delay time has run out.
// - Autoreset also waits until remaining ramp time has completed.
// - Each alarm delay is Off (0) or 1 to 3600 seconds, default Off.
// - Thermal alarm delay starts after the model cools to 95 percent.
// - Thermometer alarm delay starts when all inputs are below threshold.
// - Thermistor alarm delay starts when all values are below limits.
// - Stalled-rotor delay starts right after the alarm action completes.
// - Current-limit delay starts right after the alarm action completes.
// - Link-fault delay starts when communication is restored.
// - Load high alarm and pre-alarms start their delay at the trip.
// - Expired delay clears that alarm when other conditions hold.
module alarm_autoreset
    import retry_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES // Cycles per second tick
) (
    input wire logic clk_i, // System clock, 125 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic [N_ALARM-1:0] alarm_trip_i, // Alarm trip pulses (pins)
    input wire logic thermal_cool_i, // Thermal model at or below 95 percent
    input wire logic rtd_below_i, // All thermometer inputs below threshold
    input wire logic therm_below_i, // All thermistors below their limit
    input wire logic action_done_i, // Alarm action has been executed
    input wire logic link_ok_i, // Communication established
    input wire logic all_normal_i, // All alarm conditions normal
    input wire logic arst_enable_i, // External autoreset enable signal
    input wire logic ramp_busy_i, // Ramp time still remaining
    input wire logic reset_cmd_i, // Normal reset command from reset source
    input wire logic [1:0] run_direction_inputs, // Run forward/reverse inputs
    output logic [N_ALARM-1:0] alarm_clear_o, // Clear pulse per alarm
    output logic motor_start_o, // Start pulse after reset in level mode
    output logic [7:0] stamp_mark_o, // Trip stamp marker, 0 when none
    output logic trip_led_o, // Trip indicator
    output logic run_led_o, // Run indicator
    output logic arst_msg_o // Autoreset message flag
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_WAIT = 4'b0010,
        S_FIRE = 4'b0100,
        S_ABORT = 4'b1000
    } arst_state_e;

    // Pins cross into the clock domain through two flops each
    localparam int unsigned SYNC_W = N_ALARM + 10;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {alarm_trip_i, thermal_cool_i, rtd_below_i, therm_below_i,
                        action_done_i, link_ok_i, all_normal_i, arst_enable_i,
                        ramp_busy_i, reset_cmd_i, |run_direction_inputs};
            sync2_q <= sync1_q;
        end
    end
    logic [N_ALARM-1:0] trip_s;
    logic thermal_cool_s, rtd_below_s, therm_below_s, action_done_s, link_ok_s;
    logic all_normal_s, enable_s, ramp_busy_s, reset_cmd_s, run_dir_s;
    assign {trip_s, thermal_cool_s, rtd_below_s, therm_below_s, action_done_s, link_ok_s,
            all_normal_s, enable_s, ramp_busy_s, reset_cmd_s, run_dir_s} = sync2_q;

    logic reset_cmd_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_cmd_q <= 1'b0;
        end else begin
            reset_cmd_q <= reset_cmd_s;
        end
    end
    logic reset_rise;
    assign reset_rise = reset_cmd_s && !reset_cmd_q;

    logic [31:0] pre_q;
    logic tick_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else if (pre_q >= TICK_LEN - 1) begin
            pre_q <= 32'h0000_0000;
            tick_q <= 1'b1;
        end else begin
            pre_q <= pre_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end

    // Software registers
    logic [3:0] limit_q;
    logic level_mode_q;
    logic [11:0] delay_q [N_ALARM];
    logic wb_hit;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // limit accepts 0..10; larger writes saturate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limit_q <= LIMIT_RST;
            level_mode_q <= 1'b0;
        end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == REG_LIMIT) begin
                limit_q <= (wb_dat_i[3:0] > LIMIT_MAX) ? LIMIT_MAX : wb_dat_i[3:0];
            end else if (wb_adr_i == REG_MODE) begin
                level_mode_q <= wb_dat_i[0];
            end
        end
    end

    // Per-alarm start conditions
    logic [N_ALARM-1:0] start_ok;
    always_comb begin
        start_ok = '0;
        start_ok[A_THERMAL] = thermal_cool_s;
        start_ok[A_RTD] = rtd_below_s;
        start_ok[A_THERM] = therm_below_s;
        start_ok[A_STALL] = action_done_s;
        start_ok[A_CLIM] = action_done_s;
        start_ok[A_LINK] = link_ok_s;
        start_ok[A_LHI] = 1'b1;
        start_ok[A_LHIPRE] = 1'b1;
        start_ok[A_LLOPRE] = 1'b1;
    end

    logic [N_ALARM-1:0] latched_q;
    logic [N_ALARM-1:0] expired;
    logic [N_ALARM-1:0] running;
    logic [N_ALARM-1:0] fire_mask;
    genvar g;
    generate
        for (g = 0; g < N_ALARM; g++) begin : g_alarm
            // delay Off or 1..3600 s, default Off
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    delay_q[g] <= DELAY_OFF;
                end else if (wb_hit && wb_we_i && wb_sel_i[1:0] == 2'b11
                             && wb_adr_i == REG_DELAY0 + 8'(4 * g)) begin
                    delay_q[g] <= (wb_dat_i[11:0] > DELAY_MAX) ? DELAY_MAX : wb_dat_i[11:0];
                end
            end
            // New trip sets over a same-cycle clear
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    latched_q[g] <= 1'b0;
                end else if (trip_s[g]) begin
                    latched_q[g] <= 1'b1;
                end else if (fire_mask[g] || reset_rise) begin
                    latched_q[g] <= 1'b0;
                end
            end
            alarm_delay_timer u_timer (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .tick_i(tick_q),
                .tripped_i(latched_q[g]),
                .start_ok_i(start_ok[g]),
                .delay_i(delay_q[g]),
                .expired_o(expired[g]),
                .running_o(running[g])
            );
        end
    endgenerate

    // Attempt counter and decay timer
    logic [3:0] count_q;
    logic [9:0] decay_q;
    logic any_trip;
    logic fire;
    logic aborted;
    assign any_trip = |trip_s;
    assign aborted = count_q > limit_q;

    // ten trip-free minutes decrement; reset clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= 4'h0;
            decay_q <= 10'h000;
        end else if (reset_rise) begin
            count_q <= 4'h0;
            decay_q <= 10'h000;
        end else if (any_trip) begin
            count_q <= (count_q == 4'hF) ? count_q : count_q + 4'h1;
            decay_q <= 10'h000;
        end else if (tick_q) begin
            if (decay_q >= 10'(DECAY_TICKS - 1)) begin
                decay_q <= 10'h000;
                if (count_q != 4'h0) begin
                    count_q <= count_q - 4'h1;
                end
            end else begin
                decay_q <= decay_q + 10'h001;
            end
        end
    end

    // Autoreset sequencing
    arst_state_e state_q;
    logic cond_ok;
    // all gates for an automatic reset
    assign cond_ok = (limit_q != 4'h0) && all_normal_s && enable_s && !ramp_busy_s
                     && !aborted && (running == '0) && (expired != '0);
    assign fire = (state_q == S_WAIT) && cond_ok;
    assign fire_mask = fire ? expired : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (aborted && latched_q != '0) begin
                        state_q <= S_ABORT;
                    end else if (limit_q != 4'h0 && (latched_q & ~expired & ~running) == '0
                                 && latched_q != '0) begin
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (aborted) begin
                        state_q <= S_ABORT;
                    end else if (fire) begin
                        state_q <= S_FIRE;
                    end else if (latched_q == '0 || limit_q == 4'h0) begin
                        state_q <= S_IDLE;
                    end
                end
                S_FIRE: begin
                    state_q <= S_IDLE;
                end
                S_ABORT: begin
                    if (reset_rise) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // expired delays clear their alarms; level mode starts motor
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_clear_o <= '0;
            motor_start_o <= 1'b0;
        end else begin
            alarm_clear_o <= fire_mask;
            motor_start_o <= (fire || reset_rise) && level_mode_q && run_dir_s;
        end
    end

    // marker appears once the count exceeds a non-zero limit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stamp_mark_o <= 8'h00;
        end else if (reset_rise) begin
            stamp_mark_o <= 8'h00;
        end else if (limit_q != 4'h0 && count_q > limit_q) begin
            stamp_mark_o <= LIMIT_MARK;
        end
    end

    // both indicators flash in step while pending
    logic [7:0] flash_q;
    logic blink_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_q <= 8'h00;
            blink_q <= 1'b0;
            trip_led_o <= 1'b0;
            run_led_o <= 1'b0;
            arst_msg_o <= 1'b0;
        end else begin
            if (tick_q) begin
                flash_q <= (flash_q >= FLASH_HALF_S - 8'h01) ? 8'h00 : flash_q + 8'h01;
                blink_q <= (flash_q >= FLASH_HALF_S - 8'h01) ? !blink_q : blink_q;
            end
            trip_led_o <= (state_q == S_WAIT) ? blink_q : (latched_q != '0);
            run_led_o <= (state_q == S_WAIT) && blink_q;
            arst_msg_o <= (state_q == S_WAIT);
        end
    end

    // Wishbone read path; unmapped addresses read zero and still ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i) begin
                if (wb_adr_i == REG_LIMIT) begin
                    wb_dat_o <= {28'h0000000, limit_q};
                end else if (wb_adr_i == REG_COUNT) begin
                    wb_dat_o <= {28'h0000000, count_q};
                end else if (wb_adr_i == REG_STATUS) begin
                    wb_dat_o[ST_PENDING] <= (state_q == S_WAIT);
                    wb_dat_o[ST_ABORTED] <= (state_q == S_ABORT);
                    wb_dat_o[ST_MARK_LO +: 8] <= stamp_mark_o;
                    wb_dat_o[ST_RUN_LO +: ST_RUN_W] <= running;
                end else if (wb_adr_i == REG_MODE) begin
                    wb_dat_o <= {31'h00000000, level_mode_q};
                end else if (wb_adr_i >= REG_DELAY0 && wb_adr_i < REG_DELAY0 + 8'(4 * N_ALARM)
                             && wb_adr_i[1:0] == 2'b00) begin
                    wb_dat_o <= {20'h00000, delay_q[4'((wb_adr_i - REG_DELAY0) >> 2)]};
                end
            end
        end
    end
endmodule
`default_nettype wire

// [hdl/alarm_delay_timer.sv]
// One per-alarm autoreset delay counter on the one-second tick
`default_nettype none
module alarm_delay_timer
    import retry_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic tick_i, // One-second tick
    input wire logic tripped_i, // Alarm is latched
    input wire logic start_ok_i, // Start condition for this alarm met
    input wire logic [11:0] delay_i, // Programmed delay, 0 means off
    output logic expired_o, // Delay has run out
    output logic running_o // Delay is counting
);
    logic [11:0] cnt_q;
    logic run_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || !tripped_i || delay_i == DELAY_OFF) begin
            cnt_q <= 12'h000;
            run_q <= 1'b0;
        end else if (!run_q) begin
            run_q <= start_ok_i;
        end else if (tick_i && cnt_q < delay_i) begin
            cnt_q <= cnt_q + 12'h001;
        end
    end

    assign expired_o = run_q && (cnt_q >= delay_i) && (delay_i != DELAY_OFF);
    assign running_o = run_q && !expired_o;
endmodule
`default_nettype wire

// [hdl/retry_pkg.sv]
// Constants, register map and carrier types for the alarm autoreset controller
`default_nettype none
package retry_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
    localparam int unsigned DECAY_MIN = 10;
    localparam int unsigned DECAY_TICKS = DECAY_MIN * 60;
    localparam int unsigned N_ALARM = 9;
    localparam logic [3:0] LIMIT_MAX = 4'hA;
    localparam logic [3:0] LIMIT_RST = 4'h0;
    localparam logic [11:0] DELAY_OFF = 12'h000;
    localparam logic [11:0] DELAY_MAX = 12'hE10;
    localparam logic [7:0] LIMIT_MARK = 8'h41;
    localparam logic [7:0] FLASH_HALF_S = 8'h01;
    // Alarm indices
    localparam int unsigned A_THERMAL = 0;
    localparam int unsigned A_RTD = 1;
    localparam int unsigned A_THERM = 2;
    localparam int unsigned A_STALL = 3;
    localparam int unsigned A_CLIM = 4;
    localparam int unsigned A_LINK = 5;
    localparam int unsigned A_LHI = 6;
    localparam int unsigned A_LHIPRE = 7;
    localparam int unsigned A_LLOPRE = 8;
    // Register byte addresses (byte address = word index * 4)
    localparam logic [7:0] REG_LIMIT = 8'h00;
    localparam logic [7:0] REG_COUNT = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MODE = 8'h0C;
    localparam logic [7:0] REG_DELAY0 = 8'h20;
    // Status field positions
    localparam int unsigned ST_PENDING = 0;
    localparam int unsigned ST_ABORTED = 1;
    localparam int unsigned ST_MARK_LO = 8;
    localparam int unsigned ST_RUN_LO = 16;
    localparam int unsigned ST_RUN_W = 9;
    typedef struct packed {
        logic [N_ALARM-1:0] tripped;
        logic [N_ALARM-1:0] start_ok;
    } alarm_in_s;
    typedef struct packed {
        logic trip_led;
        logic run_led;
        logic msg_flag;
    } indicate_s;
endpackage
`default_nettype wire

// [tb/alarm_autoreset_props.sv]
// Port-level checker for the alarm autoreset controller
`default_nettype none
module alarm_autoreset_props
    import retry_pkg::*;
#(
    parameter int unsigned TICK_LEN = 10 // Cycles per second tick
) (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_ack_o, // Bus acknowledge
    input wire logic all_normal_i, // All conditions normal
    input wire logic arst_enable_i, // Autoreset enable
    input wire logic ramp_busy_i, // Ramp remaining
    input wire logic reset_cmd_i, // Manual reset command
    input wire logic [N_ALARM-1:0] alarm_clear_o, // Clear pulses
    input wire logic motor_start_o, // Start pulse
    input wire logic [7:0] stamp_mark_o, // Stamp marker
    input wire logic trip_led_o, // Trip indicator
    input wire logic run_led_o, // Run indicator
    input wire logic arst_msg_o // Autoreset flag
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Eight quiet cycles cover the two-flop input sync plus the fire and clear stages
    property p_no_enable;
        !arst_enable_i [*8] |-> alarm_clear_o == '0;
    endproperty
    property p_abnormal;
        !all_normal_i [*8] |-> alarm_clear_o == '0;
    endproperty
    property p_ramp;
        ramp_busy_i [*8] |-> alarm_clear_o == '0;
    endproperty
    property p_blink;
        arst_msg_o && $past(arst_msg_o) && $changed(trip_led_o)
            |=> ($stable(trip_led_o) || !arst_msg_o) [*8];
    endproperty
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_leds_together;
        arst_msg_o |-> trip_led_o == run_led_o;
    endproperty
    property p_mark_value;
        stamp_mark_o == 8'h00 || stamp_mark_o == LIMIT_MARK;
    endproperty
    property p_cmd_clears_mark;
        $rose(reset_cmd_i) |-> ##[4:8] stamp_mark_o == 8'h00;
    endproperty
    property p_start_pulse;
        motor_start_o |=> !motor_start_o;
    endproperty
    property p_clear_pulse;
        alarm_clear_o != '0 |=> alarm_clear_o == '0;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("clear while disabled");
    a_abnormal: assert property (p_abnormal) else $error("clear while abnormal");
    a_ramp: assert property (p_ramp) else $error("clear during ramp");
    a_blink: assert property (p_blink) else $error("blink period short");
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_leds_together: assert property (p_leds_together) else $error("leds apart");
    a_mark_value: assert property (p_mark_value) else $error("bad marker");
    a_cmd_clears_mark: assert property (p_cmd_clears_mark) else $error("mark kept");
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear too long");
    c_clear: cover property (alarm_clear_o != '0);
    c_start: cover property (motor_start_o);
    c_mark: cover property (stamp_mark_o == LIMIT_MARK);
endmodule

bind alarm_autoreset alarm_autoreset_props #(.TICK_LEN(TICK_LEN)) i_props (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .all_normal_i, .arst_enable_i,
    .ramp_busy_i, .reset_cmd_i, .alarm_clear_o, .motor_start_o, .stamp_mark_o,
    .trip_led_o, .run_led_o, .arst_msg_o
);
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the alarm autoreset controller
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import retry_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic [8:0] trip = 9'h000;
    logic [4:0] cond = 5'h00;
    logic nrm = 1'b1, en = 1'b1, ramp = 1'b0, rcmd = 1'b0;
    logic [1:0] rdir = 2'h0;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, motor_start_o, trip_led_o, run_led_o, arst_msg_o, msg, st;
    logic [8:0] alarm_clear_o, seen;
    logic [7:0] stamp_mark_o;
    int err_count = 0, tests_run = 0, n;
    // Ten cycles per second keeps the ten-minute decay near 6000 cycles
    alarm_autoreset #(.TICK_LEN(10)) i_dut (
        .clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o, .wb_ack_o, .alarm_trip_i(trip),
        .thermal_cool_i(cond[0]), .rtd_below_i(cond[1]), .therm_below_i(cond[2]),
        .action_done_i(cond[3]), .link_ok_i(cond[4]), .all_normal_i(nrm),
        .arst_enable_i(en), .ramp_busy_i(ramp), .reset_cmd_i(rcmd),
        .run_direction_inputs(rdir), .alarm_clear_o, .motor_start_o, .stamp_mark_o,
        .trip_led_o, .run_led_o, .arst_msg_o
    );
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (wb_ack_o !== 1'b1) begin
            chk(wb_ack_o, 1'b1);
            give_verdict();
        end
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 32'h0);
        chk(q, exp);
    endtask
    task automatic tr(input int i);
        @(posedge clk_i);
        trip <= 9'h001 << i;
        @(posedge clk_i);
        trip <= 9'h000;
    endtask
    // Manual reset command; the start pulse is collected while it is held
    task automatic rc;
        st = 1'b0;
        @(posedge clk_i);
        rcmd <= 1'b1;
        repeat (10) begin
            @(posedge clk_i);
            st = st | motor_start_o;
        end
        rcmd <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    // Waits for a clear pulse; an expected one that never comes ends the run
    task automatic wclr(input int max, input logic must);
        seen = 9'h000;
        msg = 1'b0;
        n = 0;
        while (n < max && seen === 9'h000) begin
            @(posedge clk_i);
            n++;
            seen = alarm_clear_o;
            msg = msg | arst_msg_o;
        end
        if (must && seen === 9'h000) begin
            chk(seen !== 9'h000, 1'b1);
            give_verdict();
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(REG_COUNT, 32'h0);
        rd(REG_LIMIT, 32'h0);
        rd(REG_DELAY0, 32'h0);
        rd(REG_STATUS, 32'h0);
        wb(8'h10, 1'b1, 32'h7);
        rd(8'h10, 32'h0);
        wb(REG_COUNT, 1'b1, 32'h5);
        rd(REG_COUNT, 32'h0);
        wb(REG_LIMIT, 1'b1, 32'hF);
        rd(REG_LIMIT, 32'hA);
        wb(REG_DELAY0, 1'b1, 32'hFFF);
        rd(REG_DELAY0, 32'hE10);
        $display("test 1 done");
        wb(REG_LIMIT, 1'b1, 32'h0);
        wb(REG_DELAY0 + 8'h18, 1'b1, 32'h3);
        tr(6);
        wclr(60, 1'b0);
        chk(seen, 8'h00);
        rc();
        chk(st, 1'b0);
        $display("test 2 done");
        wb(REG_LIMIT, 1'b1, 32'h3);
        tr(6);
        wclr(60, 1'b1);
        chk(seen, 8'h40);
        chk(n >= 21 && n <= 45, 1'b1);
        chk(msg, 1'b1);
        rd(REG_COUNT, 32'h1);
        $display("test 3 done");
        wb(REG_LIMIT, 1'b1, 32'hA);
        for (int i = 0; i < N_ALARM; i++) begin
            wb(REG_DELAY0 + 8'(4 * i), 1'b1, 32'h1);
        end
        // Stall and current limit share the alarm-action condition
        for (int i = 0; i < 6; i++) begin
            tr(i);
            wclr(40, 1'b0);
            chk(seen, 8'h00);
            cond[(i <= 3) ? i : i - 1] <= 1'b1;
            wclr(40, 1'b1);
            chk(seen, 8'h01 << i);
            cond <= 5'h00;
        end
        $display("test 4 done");
        // Each gate is tried on a different load-monitor alarm
        for (int g = 0; g < 3; g++) begin
            nrm <= (g != 0);
            en <= (g != 1);
            ramp <= (g == 2);
            tr(6 + g);
            wclr(40, 1'b0);
            chk(seen, 8'h00);
            nrm <= 1'b1;
            en <= 1'b1;
            ramp <= 1'b0;
            wclr(40, 1'b1);
            chk(seen, 32'h40 << g);
        end
        $display("test 5 done");
        rc();
        rd(REG_COUNT, 32'h0);
        wb(REG_LIMIT, 1'b1, 32'h1);
        wb(REG_MODE, 1'b1, 32'h1);
        rdir <= 2'h1;
        tr(6);
        wclr(40, 1'b1);
        chk(seen, 8'h40);
        tr(6);
        wclr(60, 1'b0);
        chk(seen, 8'h00);
        chk(stamp_mark_o, LIMIT_MARK);
        wb(REG_STATUS, 1'b0, 32'h0);
        chk(q & 32'h0000FF02, 32'h00004102);
        rc();
        chk(st, 1'b1);
        chk(stamp_mark_o, 8'h00);
        rd(REG_COUNT, 32'h0);
        $display("test 6 done");
        rdir <= 2'h0;
        wb(REG_LIMIT, 1'b1, 32'h3);
        tr(6);
        wclr(40, 1'b1);
        repeat (5000) @(posedge clk_i);
        rd(REG_COUNT, 32'h1);
        repeat (1500) @(posedge clk_i);
        rd(REG_COUNT, 32'h0);
        repeat (6200) @(posedge clk_i);
        rd(REG_COUNT, 32'h0);
        $display("test 7 done");
        give_verdict();
    end
endmodule
`default_nettype wire
